// >>> hw/slvm_pkg.sv
package slvm_pkg;

   // --------------------------------------------------------------------------
   // Register map, byte addresses on the Wishbone bus
   // --------------------------------------------------------------------------
   localparam logic [3:0] ADDR_CTRL = 4'h0;       // Monitor control and status
   localparam logic [3:0] ADDR_IRQCTL = 4'h4;     // Interrupt flag and enable
   localparam logic [3:0] ADDR_STATUS = 4'h8;     // Sticky event status
   localparam logic [3:0] ADDR_MASK = 4'hc;       // Event mask

   // --------------------------------------------------------------------------
   // Control register field positions
   // --------------------------------------------------------------------------
   localparam int CTRL_DEB_HI = 7;                // Debounce select, top bit
   localparam int CTRL_DEB_LO = 6;                // Debounce select, low bit
   localparam int CTRL_LOWFLAG = 5;               // Read-only comparator flag
   localparam int CTRL_DETEN = 4;                 // Detector enable
   localparam int CTRL_BGBUF = 3;                 // Bandgap buffer enable
   localparam int CTRL_THR_HI = 2;                // Threshold select, top bit

   // Interrupt control register field positions
   localparam int IRQ_FLAG = 5;                   // Low voltage request flag
   localparam int IRQ_EN = 1;                     // Low voltage request enable
   localparam int IRQ_GLOBAL = 0;                 // Global interrupt enable

   // Event bits in status and mask registers
   localparam int EV_LOW = 0;                     // Debounced low voltage seen
   localparam int EV_RISE = 1;                    // Raw flag went high
   localparam int EV_NUM = 2;                     // Number of events

   localparam logic [7:0] RESET_BYTE = 8'h00;     // Power-on value of registers

   // --------------------------------------------------------------------------
   // Debounce codes and their counts of slow clock periods
   // --------------------------------------------------------------------------
   localparam logic [1:0] DEB_SHORT = 2'h0;
   localparam logic [1:0] DEB_MID = 2'h1;
   localparam logic [1:0] DEB_LONG = 2'h2;
   localparam logic [3:0] TICKS_SHORT = 4'h2;     // Gives 1 to 2 periods
   localparam logic [3:0] TICKS_MID = 4'h4;       // Gives 3 to 4 periods
   localparam logic [3:0] TICKS_LONG = 4'h8;      // Gives 7 to 8 periods

   // Slow RC clock period and system clock rate
   localparam int SLOW_PERIOD_NS = 31250;         // 32 kHz nominal
   localparam int SYS_PERIOD_NS = 100;            // 10 MHz system clock
   localparam int SLOW_DIV = SLOW_PERIOD_NS / SYS_PERIOD_NS;

   // Operating modes of the core
   typedef enum logic [1:0]
   {
      MODE_FAST,
      MODE_SLOW,
      MODE_IDLE,
      MODE_SLEEP
   } slvm_mode_t;

   // Analogue control signals grouped for the comparator macro
   typedef struct packed
   {
      logic detOn;                                // Comparator powered
      logic bandgapOn;                            // Bandgap reference powered
      logic bufOn;                                // Bandgap buffer powered
      logic [2:0] threshold;                      // Trip voltage code
   } slvm_ana_t;

endpackage : slvm_pkg

// >>> hw/slvm_top.sv
`timescale 1ns/100ps
// Contract
// - Enable bit switches detector on/off
// - Three-bit code selects eight trip voltages
// - Read-only flag shows supply below threshold
// - Sleep mode always forces detector off
// - Other modes follow the enable bit
// - Two-bit code selects debounce duration
// - Request flag only after debounced low
// - Request in idle wakes the core, but only while the request flag is clear
// - Bandgap on for detector, brownout, buffer
// - Flag follows comparator without hysteresis
// - Request flag bit5, enable bit1, reset zero
// - Enable gates request; flags still set
module slvm_top
#(
   parameter int SLOW_DIV = slvm_pkg::SLOW_DIV,  // System cycles per slow period
   parameter int TICK_W = 12                     // Width of the divider count
)
(
   input wire logic clk_sys,
   input wire logic rstn,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Core and analogue side
   input wire slvm_pkg::slvm_mode_t coreMode,
   input wire logic brownoutEnable,
   input wire logic comparatorLow,
   output slvm_pkg::slvm_ana_t anaCtrl,
   output logic lvIrqReq,
   output logic idleWake,
   output logic irq
);

   // --------------------------------------------------------------------------
   // Register state
   // --------------------------------------------------------------------------
   logic [7:0] ctrl_q, ctrl_d;                   // Writable control bits
   logic irqFlag_q, irqFlag_d;                   // Low voltage request flag
   logic irqEn_q, irqEn_d;                       // Request enable
   logic globalEn_q, globalEn_d;                 // Global interrupt enable
   logic [1:0] evStat_q, evStat_d;               // Sticky event status
   logic [1:0] evMask_q, evMask_d;               // Event mask
   logic ack_q, ack_d;                           // Bus acknowledge
   logic [31:0] rdat_q, rdat_d;                  // Registered read data
   // Comparator synchroniser and debounce
   logic cmpMeta_q, cmpSync_q;                   // Two-stage synchroniser
   logic lowPrev_q;                              // Previous flag for edge
   logic [TICK_W-1:0] div_q, div_d;              // Slow tick divider
   logic [3:0] deb_q, deb_d;                     // Slow ticks spent low
   logic fired_q, fired_d;                       // Request already raised
   logic slowTick;                               // One-cycle slow clock enable
   logic detOn;                                  // Detector effectively on
   logic lowFlag;                                // Flag visible to software
   logic [3:0] debTarget;                        // Ticks needed before request
   logic debDone;                                // Debounced low reached
   logic busWr, busRd;                           // Accepted bus cycle

   // --------------------------------------------------------------------------
   // Detector power and analogue control
   // --------------------------------------------------------------------------
   always_comb
   begin
      // Sleep wins over the enable bit to save current
      detOn = ctrl_q[slvm_pkg::CTRL_DETEN] &&
              (coreMode != slvm_pkg::MODE_SLEEP);
      anaCtrl.detOn = detOn;
      anaCtrl.bufOn = ctrl_q[slvm_pkg::CTRL_BGBUF];
      anaCtrl.bandgapOn = detOn || brownoutEnable ||
                          ctrl_q[slvm_pkg::CTRL_BGBUF];
      anaCtrl.threshold = ctrl_q[slvm_pkg::CTRL_THR_HI:0];
   end

   // --------------------------------------------------------------------------
   // Comparator synchroniser, no filtering so near-threshold chatter shows
   // --------------------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         cmpMeta_q <= 1'b0;
         cmpSync_q <= 1'b0;
         lowPrev_q <= 1'b0;
      end
      else
      begin
         cmpMeta_q <= comparatorLow;
         cmpSync_q <= cmpMeta_q;
         lowPrev_q <= lowFlag;
      end
   end

   // Flag reads zero while the detector is off, hence no stale value
   assign lowFlag = cmpSync_q && detOn;

   // --------------------------------------------------------------------------
   // Slow clock divider and debounce counter
   // --------------------------------------------------------------------------
   always_comb
   begin
      // Free-running divider; phase unknown to the low edge gives the range
      slowTick = (div_q == TICK_W'(SLOW_DIV - 1));
      div_d = slowTick ? '0 : div_q + 1'b1;
      // 00 and 11 share the short duration
      if (ctrl_q[slvm_pkg::CTRL_DEB_HI:slvm_pkg::CTRL_DEB_LO] == slvm_pkg::DEB_MID)
      begin
         debTarget = slvm_pkg::TICKS_MID;
      end
      else if (ctrl_q[slvm_pkg::CTRL_DEB_HI:slvm_pkg::CTRL_DEB_LO] == slvm_pkg::DEB_LONG)
      begin
         debTarget = slvm_pkg::TICKS_LONG;
      end
      else
      begin
         debTarget = slvm_pkg::TICKS_SHORT;
      end
      debDone = (deb_q >= debTarget);
      deb_d = deb_q;
      fired_d = fired_q;
      if (!lowFlag)
      begin
         // Restart whenever the flag drops
         deb_d = '0;
         fired_d = 1'b0;
      end
      else if (slowTick && !debDone)
      begin
         deb_d = deb_q + 1'b1;
      end
      if (lowFlag && debDone)
      begin
         fired_d = 1'b1;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         div_q <= '0;
         deb_q <= '0;
         fired_q <= 1'b0;
      end
      else
      begin
         div_q <= div_d;
         deb_q <= deb_d;
         fired_q <= fired_d;
      end
   end

   // --------------------------------------------------------------------------
   // Bus decode and register next values
   // --------------------------------------------------------------------------
   assign busWr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q && wb_sel_i[0];
   assign busRd = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q;

   always_comb
   begin
      logic rise;
      logic reqEvt;
      rise = lowFlag && !lowPrev_q;
      // One pulse per debounced low episode
      reqEvt = lowFlag && debDone && !fired_q;
      ctrl_d = ctrl_q;
      irqFlag_d = irqFlag_q;
      irqEn_d = irqEn_q;
      globalEn_d = globalEn_q;
      evStat_d = evStat_q;
      evMask_d = evMask_q;
      ack_d = wb_cyc_i && wb_stb_i && !ack_q;
      rdat_d = '0;
      if (busWr && wb_adr_i == slvm_pkg::ADDR_CTRL)
      begin
         // Flag bit is read-only and stays out of storage
         ctrl_d = wb_dat_i[7:0] & ~(8'h01 << slvm_pkg::CTRL_LOWFLAG);
      end
      else if (busWr && wb_adr_i == slvm_pkg::ADDR_IRQCTL)
      begin
         irqFlag_d = wb_dat_i[slvm_pkg::IRQ_FLAG];
         irqEn_d = wb_dat_i[slvm_pkg::IRQ_EN];
         globalEn_d = wb_dat_i[slvm_pkg::IRQ_GLOBAL];
      end
      else if (busWr && wb_adr_i == slvm_pkg::ADDR_STATUS)
      begin
         evStat_d = evStat_q & ~wb_dat_i[1:0];      // Write one to clear
      end
      else if (busWr && wb_adr_i == slvm_pkg::ADDR_MASK)
      begin
         evMask_d = wb_dat_i[1:0];
      end
      // Hardware set wins over a same-cycle clear
      if (reqEvt)
      begin
         irqFlag_d = 1'b1;
         evStat_d[slvm_pkg::EV_LOW] = 1'b1;
      end
      if (rise)
      begin
         evStat_d[slvm_pkg::EV_RISE] = 1'b1;
      end
      // Read mux; unmapped addresses read zero but still acknowledge
      if (busRd && wb_adr_i == slvm_pkg::ADDR_CTRL)
      begin
         rdat_d[7:0] = ctrl_q;
         rdat_d[slvm_pkg::CTRL_LOWFLAG] = lowFlag;
      end
      else if (busRd && wb_adr_i == slvm_pkg::ADDR_IRQCTL)
      begin
         rdat_d[slvm_pkg::IRQ_FLAG] = irqFlag_q;
         rdat_d[slvm_pkg::IRQ_EN] = irqEn_q;
         rdat_d[slvm_pkg::IRQ_GLOBAL] = globalEn_q;
      end
      else if (busRd && wb_adr_i == slvm_pkg::ADDR_STATUS)
      begin
         rdat_d[1:0] = evStat_q;
      end
      else if (busRd && wb_adr_i == slvm_pkg::ADDR_MASK)
      begin
         rdat_d[1:0] = evMask_q;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn)
   begin
      if (!rstn)
      begin
         ctrl_q <= slvm_pkg::RESET_BYTE;
         irqFlag_q <= 1'b0;
         irqEn_q <= 1'b0;
         globalEn_q <= 1'b0;
         evStat_q <= '0;
         evMask_q <= '0;
         ack_q <= 1'b0;
         rdat_q <= '0;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         irqFlag_q <= irqFlag_d;
         irqEn_q <= irqEn_d;
         globalEn_q <= globalEn_d;
         evStat_q <= evStat_d;
         evMask_q <= evMask_d;
         ack_q <= ack_d;
         rdat_q <= rdat_d;
      end
   end

   // --------------------------------------------------------------------------
   // Outputs
   // --------------------------------------------------------------------------
   assign wb_ack_o = ack_q;
   assign wb_dat_o = rdat_q;
   // Enable gates the vector request; the flag itself sets regardless
   assign lvIrqReq = irqFlag_q && irqEn_q && globalEn_q;
   logic reqEvt_w;                                // Wake source, set cause but only while the request flag is clear
   assign reqEvt_w = lowFlag && debDone && !fired_q && !irqFlag_q;
   // Presetting the flag before idle blocks a new wake edge
   assign idleWake = reqEvt_w && (coreMode == slvm_pkg::MODE_IDLE);
   assign irq = |(evStat_q & evMask_q);


   // --------------------------------------------------------------------------
   // Assertions
   // --------------------------------------------------------------------------
   a_sleep_forces_off: assert property (@(posedge clk_sys) disable iff (!rstn)
      (coreMode == slvm_pkg::MODE_SLEEP) |-> !anaCtrl.detOn)
      else $error("detector on during sleep");
   a_mode_follows_en: assert property (@(posedge clk_sys) disable iff (!rstn)
      (coreMode != slvm_pkg::MODE_SLEEP) |->
      (anaCtrl.detOn == ctrl_q[slvm_pkg::CTRL_DETEN]))
      else $error("detector does not follow enable");
   a_bandgap_on: assert property (@(posedge clk_sys) disable iff (!rstn)
      (anaCtrl.detOn || brownoutEnable || ctrl_q[slvm_pkg::CTRL_BGBUF]) |-> anaCtrl.bandgapOn)
      else $error("bandgap off while needed");
   a_flag_debounced: assert property (@(posedge clk_sys) disable iff (!rstn)
      $rose(irqFlag_q) && !$past(busWr) |-> $past(lowFlag) && $past(debDone))
      else $error("request flag set without debounce");
   a_flag_sticky: assert property (@(posedge clk_sys) disable iff (!rstn)
      irqFlag_q && !busWr |=> irqFlag_q)
      else $error("request flag dropped without write");
   a_gate_request: assert property (@(posedge clk_sys) disable iff (!rstn)
      lvIrqReq |-> irqEn_q && globalEn_q)
      else $error("request without enables");
   a_deb_restart: assert property (@(posedge clk_sys) disable iff (!rstn)
      !lowFlag |=> deb_q == 4'h0)
      else $error("debounce count not restarted");
   a_thr_follow: assert property (@(posedge clk_sys) disable iff (!rstn)
      anaCtrl.threshold == ctrl_q[slvm_pkg::CTRL_THR_HI:0])
      else $error("threshold code mismatch");
   a_ack_one: assert property (@(posedge clk_sys) disable iff (!rstn)
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");

endmodule : slvm_top

// >>> verif/test_slvm_top.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Compare helper, counts every check and reports mismatches
// ----------------------------------------------------------------------
`define CHECK(nm, exp, got) \
   begin \
      n_compared++; \
      if ((got) !== (exp)) \
      begin \
         fail_count++; \
         $display("wrong value %s expected %h seen %h", nm, exp, got); \
      end \
   end

module test_slvm_top;
   localparam int DIV = 4; // Short slow period keeps debounce waits brief
   logic clk_sys, rstn, wbCyc, wbStb, wbWe; // Clock, reset, bus strobes
   logic [3:0] wbAdr, wbSel; // Bus address and byte enables
   logic [31:0] wbDin, wbDout; // Bus write and read data
   logic wbAck, brownoutEnable, comparatorLow, lvIrqReq, idleWake, irq;
   slvm_pkg::slvm_mode_t coreMode; // Core operating mode
   slvm_pkg::slvm_ana_t anaCtrl; // Analogue controls seen at the macro
   int fail_count, n_compared; // Mismatch and comparison counters

   slvm_top #(.SLOW_DIV(DIV), .TICK_W(12)) u_slvm_top
   (
      .clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
      .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDin),
      .wb_dat_o(wbDout), .wb_ack_o(wbAck), .coreMode(coreMode),
      .brownoutEnable(brownoutEnable), .comparatorLow(comparatorLow),
      .anaCtrl(anaCtrl), .lvIrqReq(lvIrqReq), .idleWake(idleWake), .irq(irq)
   );

   // ----------------------------------------------------------------------
   // Bus and reporting tasks
   // ----------------------------------------------------------------------
   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : tally_and_finish

   // One classic cycle; ack is read before the edge updates land
   task automatic wbXfer(input logic we, input logic [3:0] a, input logic [7:0] d,
                         input logic [3:0] s, output logic [7:0] q);
      int i;
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= a;
      wbSel <= s;
      wbDin <= {24'h000000, d};
      i = 0;
      do
      begin
         @(posedge clk_sys);
         i++;
      end
      while (wbAck !== 1'b1 && i < 20);
      q = wbDout[7:0];
      // A slave that never answers ends the run here
      if (wbAck !== 1'b1)
      begin
         fail_count++;
         tally_and_finish();
      end
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe <= 1'b0;
      @(posedge clk_sys);
   endtask : wbXfer

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      logic [7:0] q;
      wbXfer(1'b1, a, d, 4'h1, q);
   endtask : wr

   task automatic rdChk(input string nm, input logic [3:0] a, input logic [7:0] e);
      logic [7:0] q;
      wbXfer(1'b0, a, 8'h00, 4'h1, q);
      `CHECK(nm, e, q)
   endtask : rdChk

   // ----------------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------------
   task automatic testReset;
      rdChk("ctrl", slvm_pkg::ADDR_CTRL, slvm_pkg::RESET_BYTE);
      rdChk("irqctl", slvm_pkg::ADDR_IRQCTL, 8'h00);
      rdChk("status", slvm_pkg::ADDR_STATUS, 8'h00);
      rdChk("mask", slvm_pkg::ADDR_MASK, 8'h00);
      rdChk("unmapped", 4'h2, 8'h00);
      `CHECK("anaCtrl", 6'h00, anaCtrl)
      $display("test reset done");
   endtask : testReset

   // Fields, read-only bit, refused write, mode gating and bandgap terms
   task automatic testCtrl;
      logic [7:0] q;
      logic [7:0] cv [3];
      logic en;
      cv = '{8'h00, 8'h10, 8'h08};
      wr(slvm_pkg::ADDR_CTRL, 8'hff);
      rdChk("ctrl rw", slvm_pkg::ADDR_CTRL, 8'hdf);
      wbXfer(1'b1, slvm_pkg::ADDR_CTRL, 8'h00, 4'he, q);
      rdChk("sel0 low", slvm_pkg::ADDR_CTRL, 8'hdf);
      for (int t = 0; t < 8; t++)
      begin
         wr(slvm_pkg::ADDR_CTRL, 8'h10 | 8'(t));
         `CHECK("threshold", 3'(t), anaCtrl.threshold)
      end
      for (int i = 0; i < 3; i++)
      begin
         wr(slvm_pkg::ADDR_CTRL, cv[i]);
         for (int m = 0; m < 4; m++)
         begin
            coreMode <= slvm_pkg::slvm_mode_t'(m);
            // Brownout only in slow mode so the other modes show the detector and buffer terms alone
            brownoutEnable <= (m == 1);
            @(posedge clk_sys);
            @(posedge clk_sys);
            en = cv[i][4] & (m != 3);
            `CHECK("detOn", en, anaCtrl.detOn)
            `CHECK("bandgapOn", en | cv[i][3] | (m == 1), anaCtrl.bandgapOn)
            `CHECK("bufOn", cv[i][3], anaCtrl.bufOn)
         end
      end
      coreMode <= slvm_pkg::MODE_FAST;
      brownoutEnable <= 1'b0;
      $display("test ctrl done");
   endtask : testCtrl

   // Flag tracks the comparator both ways, each transition seen
   task automatic testLowFlag;
      wr(slvm_pkg::ADDR_MASK, 8'h02);
      wr(slvm_pkg::ADDR_CTRL, 8'h10);
      repeat (4) @(posedge clk_sys);
      for (int k = 0; k < 2; k++)
      begin
         comparatorLow <= 1'b1;
         repeat (4) @(posedge clk_sys);
         rdChk("flag low", slvm_pkg::ADDR_CTRL, 8'h30);
         `CHECK("irq rise", 1'b1, irq)
         comparatorLow <= 1'b0;
         repeat (4) @(posedge clk_sys);
         rdChk("flag high", slvm_pkg::ADDR_CTRL, 8'h10);
      end
      wr(slvm_pkg::ADDR_STATUS, 8'h03);
      wr(slvm_pkg::ADDR_IRQCTL, 8'h00);
      $display("test low flag done");
   endtask : testLowFlag

   // Every debounce code timed; enable and global combinations gate the request
   task automatic testDebounce;
      int n;
      int tk;
      logic ok;
      wr(slvm_pkg::ADDR_MASK, 8'h01);
      for (int c = 0; c < 4; c++)
      begin
         tk = (c == 1) ? 4 : (c == 2) ? 8 : 2;
         wr(slvm_pkg::ADDR_CTRL, {2'(c), 6'h10});
         wr(slvm_pkg::ADDR_IRQCTL, {6'h00, c[0], c[1]});
         wr(slvm_pkg::ADDR_STATUS, 8'h03);
         comparatorLow <= 1'b1;
         n = 0;
         do
         begin
            @(posedge clk_sys);
            n++;
         end
         while (irq !== 1'b1 && n < 100);
         // No request at all ends the run at the report
         if (irq !== 1'b1)
         begin
            fail_count++;
            tally_and_finish();
         end
         ok = (n >= (tk - 1) * DIV + 2) && (n <= tk * DIV + 6);
         `CHECK("debounce time", 1'b1, ok)
         rdChk("irq flag", slvm_pkg::ADDR_IRQCTL, {6'h08, c[0], c[1]});
         `CHECK("lvIrqReq", c[0] & c[1], lvIrqReq)
         comparatorLow <= 1'b0;
         repeat (4) @(posedge clk_sys);
         wr(slvm_pkg::ADDR_STATUS, 8'h03);
         `CHECK("irq cleared", 1'b0, irq)
         wr(slvm_pkg::ADDR_IRQCTL, 8'h00);
         rdChk("flag cleared", slvm_pkg::ADDR_IRQCTL, 8'h00);
      end
      // Masked events still latch but keep the line quiet
      wr(slvm_pkg::ADDR_MASK, 8'h00);
      comparatorLow <= 1'b1;
      repeat (3 * DIV + 8) @(posedge clk_sys);
      `CHECK("irq masked", 1'b0, irq)
      rdChk("status", slvm_pkg::ADDR_STATUS, 8'h03);
      comparatorLow <= 1'b0;
      repeat (4) @(posedge clk_sys);
      wr(slvm_pkg::ADDR_STATUS, 8'h03);
      wr(slvm_pkg::ADDR_IRQCTL, 8'h00);
      $display("test debounce done");
   endtask : testDebounce

   // Wake from idle, then the flag left set by that request blocks the next wake
   task automatic testIdleWake;
      logic seen [2];
      coreMode <= slvm_pkg::MODE_IDLE;
      wr(slvm_pkg::ADDR_CTRL, 8'h10);
      wr(slvm_pkg::ADDR_IRQCTL, 8'h03);
      for (int k = 0; k < 2; k++)
      begin
         seen[k] = 1'b0;
         comparatorLow <= 1'b1;
         for (int n = 0; n < 12 * DIV; n++)
         begin
            @(posedge clk_sys);
            if (idleWake === 1'b1)
               seen[k] = 1'b1;
         end
         comparatorLow <= 1'b0;
         repeat (4) @(posedge clk_sys);
      end
      `CHECK("wake", 1'b1, seen[0])
      `CHECK("no wake", 1'b0, seen[1])
      rdChk("sticky", slvm_pkg::ADDR_IRQCTL, 8'h23);
      wr(slvm_pkg::ADDR_IRQCTL, 8'h00);
      wr(slvm_pkg::ADDR_IRQCTL, 8'h20);
      rdChk("sw set", slvm_pkg::ADDR_IRQCTL, 8'h20);
      coreMode <= slvm_pkg::MODE_FAST;
      $display("test idle wake done");
   endtask : testIdleWake

   // ----------------------------------------------------------------------
   // Clock and main sequence
   // ----------------------------------------------------------------------
   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   initial
   begin
      rstn = 1'b0;
      {wbCyc, wbStb, wbWe, brownoutEnable, comparatorLow} = 5'h00;
      wbAdr = 4'h0;
      wbSel = 4'h1;
      wbDin = 32'h00000000;
      coreMode = slvm_pkg::MODE_FAST;
      fail_count = 0;
      n_compared = 0;
      repeat (6) @(posedge clk_sys);
      rstn <= 1'b1;
      @(posedge clk_sys);
      testReset();
      testCtrl();
      testLowFlag();
      testDebounce();
      testIdleWake();
      tally_and_finish();
   end
endmodule : test_slvm_top
